// >>> dummy_end_marker_not_used.sv
`timescale 1ns/1ns

// >>> tbf_data_link.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Code generator starts only in T1 mode, never in E1 mode.
// - Transmit code comes from bits zero to five of tx_code_value.
// - Send-code bit starts the code at once and repeats while set.
// - Generator finishes the codeword by itself when sending stops.
// - Pass-through set keeps sampled framing bits; clear lets generated bits in.
// - Receive code detector works only in T1 ESF mode.
// - Code held for filter time sets detected flag and shows the code.
// - Detected flag rearms only for a new code or after a clear.
// - Code absent for disintegration time sets the cleared flag.
// - Code flags pull the interrupt low only when their masks allow.
// - Source control selects serialising tx_data_link_byte into link or Fs bits.
// - Each data link byte is sent least significant bit first.
// - After the last bit the empty flag sets and may interrupt.
// - Data link bytes go out as written, without zero stuffing.
// - D4 mode uses only the lower six bits of the byte.
// - Eight received bits fill rx_data_link_byte, set full flag, may interrupt.
// - No zero removal; first received bit lands in bit zero.
// - D4 mode reports only Fs bits, updated on multiframe boundaries.
// - Each framer sits at first-framer offset plus index minus one times stride.
module tbf_data_link
    import tbf_pkg::*;
#(
    parameter logic [2:0] FRAMER_IDX = 3'h1
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic [31:0] s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [31:0] s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic        t1_mode_i,
    input  wire logic        esf_mode_i,
    input  wire logic        tx_dl_slot_i,
    input  wire logic        system_serial_input_i,
    output logic             tx_dl_bit_o,
    input  wire logic        rx_dl_slot_i,
    input  wire logic        rx_dl_bit_i,
    input  wire logic        rx_multiframe_i,
    output logic             interrupt_out_n_o
);
    localparam logic [12:0] BASE = 13'(13'(FRAMER_IDX - 3'h1) * FRAMER_STRIDE);

    function automatic tbf_sel_e dec(input logic [31:0] a);
        logic [12:0] ix;
        ix = a[14:2] - BASE;
        if (a[31:15] != '0) return SEL_NONE;
        case (ix)
            IX_RCC:  return SEL_RCC;
            IX_RDL:  return SEL_RDL;
            IX_RCV:  return SEL_RCV;
            IX_RX_LATCHED_STATUS_SEVEN: return SEL_RX_LATCHED_STATUS_SEVEN;
            IX_RX_INTERRUPT_MASK_SEVEN: return SEL_RX_INTERRUPT_MASK_SEVEN;
            IX_TX_LINK_CONTROL_TWO: return SEL_TX_LINK_CONTROL_TWO;
            IX_TDL:  return SEL_TDL;
            IX_TCV:  return SEL_TCV;
            IX_TX_CONTROL_ONE: return SEL_TX_CONTROL_ONE;
            IX_TX_CONTROL_TWO: return SEL_TX_CONTROL_TWO;
            IX_TX_LATCHED_STATUS_TWO: return SEL_TX_LATCHED_STATUS_TWO;
            IX_TX_INTERRUPT_MASK_TWO: return SEL_TX_INTERRUPT_MASK_TWO;
            default: return SEL_NONE;
        endcase
    endfunction

    // Host-side state
    logic        awready, wready, bvalid, arready, rvalid, irq_n;
    logic [1:0]  bresp, rresp;
    logic [31:0] aw_addr, rdata;
    logic [7:0]  w_data;
    logic        w_lane;
    logic [7:0]  rcc, rx_latched_status_seven, rx_interrupt_mask_seven, tx_link_control_two, tdl, tcv, tx_control_one, tx_control_two, tx_latched_status_two, tx_interrupt_mask_two;
    logic        next_awready, next_wready, next_bvalid, next_arready;
    logic        next_rvalid, next_irq_n, next_w_lane;
    logic [1:0]  next_bresp, next_rresp;
    logic [31:0] next_aw_addr, next_rdata;
    logic [7:0]  next_w_data, next_rcc, next_rx_latched_status_seven, next_rx_interrupt_mask_seven, next_tx_link_control_two;
    logic [7:0]  next_tdl, next_tcv, next_tx_control_one, next_tx_control_two, next_tx_latched_status_two, next_tx_interrupt_mask_two;
    // Line-side state
    logic        tx_bit;
    logic [15:0] code_sh, rx_win;
    logic [3:0]  code_cnt, fdl_cnt, rx_cnt;
    logic [7:0]  fdl_sh, rx_sh, rx_byte, abs_cnt;
    logic [5:0]  rx_code, cand;
    logic [2:0]  run;
    logic        code_act;
    logic        next_tx_bit, next_code_act;
    logic [15:0] next_code_sh, next_rx_win;
    logic [3:0]  next_code_cnt, next_fdl_cnt, next_rx_cnt;
    logic [7:0]  next_fdl_sh, next_rx_sh, next_rx_byte, next_abs_cnt;
    logic [5:0]  next_rx_code, next_cand;
    logic [2:0]  next_run;
    logic        det_evt, clr_evt, full_evt, empty_evt;
    logic [15:0] cw;
    logic [7:0]  fb;

    logic [31:0] waddr;
    logic [7:0]  wdat;
    logic        wlane, do_wr, wen;
    tbf_sel_e    wsel, rsel;
    logic        code_go, fdl_src, fdl_go, win_hit;
    logic [3:0]  fdl_len;
    logic [2:0]  filt_thr;
    logic [7:0]  dis_thr;

    assign waddr = awready ? s_axi_awaddr_i : aw_addr;
    assign wdat  = wready ? s_axi_wdata_i[7:0] : w_data;
    assign wlane = wready ? s_axi_wstrb_i[0] : w_lane;
    // Address and data are taken in either order; the write fires once both are held
    assign do_wr = (!awready || s_axi_awvalid_i) && (!wready || s_axi_wvalid_i) && !bvalid;
    assign wsel  = dec(waddr);
    assign rsel  = dec(s_axi_araddr_i);
    assign wen   = do_wr && wlane;

    // A running codeword is finished after send-code or T1 mode drops; only pass-through cuts in mid-code
    assign code_go  = !tx_control_one[PASS_THRU_BIT] && (code_cnt != '0
                      || (t1_mode_i && tx_link_control_two[SEND_CODE_BIT]));
    assign fdl_src  = esf_mode_i ? tx_control_two[DL_SRC_BIT] : !tx_control_two[DL_SRC_BIT];
    assign fdl_go   = !tx_control_one[PASS_THRU_BIT] && !code_go && fdl_src;
    assign fdl_len  = esf_mode_i ? BITS_ESF : BITS_D4;
    assign filt_thr = FILT_TBL[rcc[FILT_LO +: 2]];
    assign dis_thr  = DIS_TBL[rcc[DIS_LO +: 2]];
    assign next_rx_win = {rx_dl_bit_i, rx_win[15:1]};
    assign win_hit  = next_rx_win == tbf_code_word(next_rx_win[6:1]);

    always_comb begin
        next_tx_bit   = tx_bit;
        next_code_sh  = code_sh;
        next_code_cnt = code_cnt;
        next_fdl_sh   = fdl_sh;
        next_fdl_cnt  = fdl_cnt;
        next_rx_sh    = rx_sh;
        next_rx_cnt   = rx_cnt;
        next_rx_byte  = rx_byte;
        next_rx_code  = rx_code;
        next_cand     = cand;
        next_run      = run;
        next_abs_cnt  = abs_cnt;
        next_code_act = code_act;
        det_evt       = 1'b0;
        clr_evt       = 1'b0;
        full_evt      = 1'b0;
        empty_evt     = 1'b0;
        cw            = code_cnt == '0 ? tbf_code_word(tcv[5:0]) : code_sh;
        fb            = fdl_cnt == '0 ? tdl : fdl_sh;
        if (tx_dl_slot_i) begin
            if (tx_control_one[PASS_THRU_BIT]) begin
                next_tx_bit = system_serial_input_i;
            end else if (code_go) begin
                next_tx_bit   = cw[0];
                next_code_sh  = cw >> 1;
                next_code_cnt = code_cnt + 4'h1;
            end else if (fdl_go) begin
                next_tx_bit = fb[0];
                next_fdl_sh = fb >> 1;
                if (fdl_cnt >= fdl_len - 4'h1) begin
                    next_fdl_cnt = '0;
                    empty_evt    = 1'b1;
                end else begin
                    next_fdl_cnt = fdl_cnt + 4'h1;
                end
            end else begin
                next_tx_bit = system_serial_input_i;
            end
        end
        if (rx_dl_slot_i) begin
            next_rx_sh = {rx_dl_bit_i, rx_sh[7:1]};
            if (esf_mode_i) begin
                if (rx_cnt == BITS_ESF - 4'h1) begin
                    next_rx_cnt  = '0;
                    next_rx_byte = next_rx_sh;
                    full_evt     = 1'b1;
                end else begin
                    next_rx_cnt = rx_cnt + 4'h1;
                end
            end
            if (t1_mode_i && esf_mode_i && win_hit) begin
                next_abs_cnt = '0;
                if (next_rx_win[6:1] == cand && run != RUN_MAX) begin
                    next_run = run + 3'h1;
                end else if (next_rx_win[6:1] != cand) begin
                    next_cand = next_rx_win[6:1];
                    next_run  = 3'h1;
                end
                if (next_run == filt_thr && (!code_act || next_cand != rx_code)) begin
                    det_evt       = 1'b1;
                    next_rx_code  = next_cand;
                    next_code_act = 1'b1;
                end
            end else if (t1_mode_i && esf_mode_i) begin
                if (abs_cnt != ABS_MAX) begin
                    next_abs_cnt = abs_cnt + 8'h01;
                end
                if (code_act && abs_cnt == dis_thr - 8'h01) begin
                    clr_evt       = 1'b1;
                    next_code_act = 1'b0;
                    next_run      = '0;
                end
            end
        end
        // Six Fs bits per superframe end up in the top of the shifter
        if (!esf_mode_i && rx_multiframe_i) begin
            next_rx_byte = {2'b00, rx_sh[7:2]};
            next_rx_cnt  = '0;
            full_evt     = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tx_bit   <= 1'b0;
            code_sh  <= '0;
            code_cnt <= '0;
            fdl_sh   <= '0;
            fdl_cnt  <= '0;
            rx_win   <= '0;
            rx_sh    <= '0;
            rx_cnt   <= '0;
            rx_byte  <= '0;
            rx_code  <= '0;
            cand     <= '0;
            run      <= '0;
            abs_cnt  <= '0;
            code_act <= 1'b0;
        end else begin
            tx_bit   <= next_tx_bit;
            code_sh  <= next_code_sh;
            code_cnt <= next_code_cnt;
            fdl_sh   <= next_fdl_sh;
            fdl_cnt  <= next_fdl_cnt;
            if (rx_dl_slot_i) begin
                rx_win <= next_rx_win;
            end
            rx_sh    <= next_rx_sh;
            rx_cnt   <= next_rx_cnt;
            rx_byte  <= next_rx_byte;
            rx_code  <= next_rx_code;
            cand     <= next_cand;
            run      <= next_run;
            abs_cnt  <= next_abs_cnt;
            code_act <= next_code_act;
        end
    end

    always_comb begin
        next_awready = awready;
        next_wready  = wready;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_arready = arready;
        next_rvalid  = rvalid;
        next_rresp   = rresp;
        next_rdata   = rdata;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_lane  = w_lane;
        next_rcc     = rcc;
        next_rx_interrupt_mask_seven    = rx_interrupt_mask_seven;
        next_tx_link_control_two    = tx_link_control_two;
        next_tdl     = tdl;
        next_tcv     = tcv;
        next_tx_control_one    = tx_control_one;
        next_tx_control_two    = tx_control_two;
        next_tx_interrupt_mask_two    = tx_interrupt_mask_two;
        next_rx_latched_status_seven    = rx_latched_status_seven;
        next_tx_latched_status_two    = tx_latched_status_two;
        if (awready && s_axi_awvalid_i) begin
            next_aw_addr = s_axi_awaddr_i;
            next_awready = 1'b0;
        end
        if (wready && s_axi_wvalid_i) begin
            next_w_data = s_axi_wdata_i[7:0];
            next_w_lane = s_axi_wstrb_i[0];
            next_wready = 1'b0;
        end
        if (do_wr) begin
            next_bvalid = 1'b1;
            next_bresp  = wsel == SEL_NONE ? RESP_SLVERR : RESP_OKAY;
        end
        if (wen) begin
            unique case (wsel)
                SEL_RCC:  next_rcc  = wdat;
                SEL_RX_INTERRUPT_MASK_SEVEN: next_rx_interrupt_mask_seven = wdat;
                SEL_TX_LINK_CONTROL_TWO: next_tx_link_control_two = wdat;
                SEL_TDL:  next_tdl  = wdat;
                SEL_TCV:  next_tcv  = wdat;
                SEL_TX_CONTROL_ONE: next_tx_control_one = wdat;
                SEL_TX_CONTROL_TWO: next_tx_control_two = wdat;
                SEL_TX_INTERRUPT_MASK_TWO: next_tx_interrupt_mask_two = wdat;
                SEL_RX_LATCHED_STATUS_SEVEN: next_rx_latched_status_seven = rx_latched_status_seven & ~wdat;
                SEL_TX_LATCHED_STATUS_TWO: next_tx_latched_status_two = tx_latched_status_two & ~wdat;
                default:  next_rcc  = rcc;
            endcase
        end
        // Setting after the clear keeps a same-cycle event
        next_rx_latched_status_seven[CODE_DET_BIT] = next_rx_latched_status_seven[CODE_DET_BIT] | det_evt;
        next_rx_latched_status_seven[CODE_CLR_BIT] = next_rx_latched_status_seven[CODE_CLR_BIT] | clr_evt;
        next_rx_latched_status_seven[RX_FULL_BIT]  = next_rx_latched_status_seven[RX_FULL_BIT] | full_evt;
        next_tx_latched_status_two[TX_EMPTY_BIT] = next_tx_latched_status_two[TX_EMPTY_BIT] | empty_evt;
        next_rx_latched_status_seven = next_rx_latched_status_seven & RX_LATCHED_STATUS_SEVEN_USED;
        next_tx_latched_status_two = next_tx_latched_status_two & TX_LATCHED_STATUS_TWO_USED;
        if (bvalid && s_axi_bready_i) begin
            next_bvalid  = 1'b0;
            next_awready = 1'b1;
            next_wready  = 1'b1;
        end
        if (arready && s_axi_arvalid_i) begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rresp   = rsel == SEL_NONE ? RESP_SLVERR : RESP_OKAY;
            unique case (rsel)
                SEL_RCC:  next_rdata = {24'h00_0000, rcc};
                SEL_RDL:  next_rdata = {24'h00_0000, rx_byte};
                SEL_RCV:  next_rdata = {26'h000_0000, rx_code};
                SEL_RX_LATCHED_STATUS_SEVEN: next_rdata = {24'h00_0000, rx_latched_status_seven};
                SEL_RX_INTERRUPT_MASK_SEVEN: next_rdata = {24'h00_0000, rx_interrupt_mask_seven};
                SEL_TX_LINK_CONTROL_TWO: next_rdata = {24'h00_0000, tx_link_control_two};
                SEL_TDL:  next_rdata = {24'h00_0000, tdl};
                SEL_TCV:  next_rdata = {24'h00_0000, tcv};
                SEL_TX_CONTROL_ONE: next_rdata = {24'h00_0000, tx_control_one};
                SEL_TX_CONTROL_TWO: next_rdata = {24'h00_0000, tx_control_two};
                SEL_TX_LATCHED_STATUS_TWO: next_rdata = {24'h00_0000, tx_latched_status_two};
                SEL_TX_INTERRUPT_MASK_TWO: next_rdata = {24'h00_0000, tx_interrupt_mask_two};
                default:  next_rdata = '0;
            endcase
        end
        if (rvalid && s_axi_rready_i) begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
        next_irq_n = ~|((rx_latched_status_seven & rx_interrupt_mask_seven) | (tx_latched_status_two & tx_interrupt_mask_two));
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rresp   <= RESP_OKAY;
            rdata   <= '0;
            aw_addr <= '0;
            w_data  <= RESET_8;
            w_lane  <= 1'b0;
            rcc     <= RESET_8;
            rx_latched_status_seven    <= RESET_8;
            rx_interrupt_mask_seven    <= RESET_8;
            tx_link_control_two    <= RESET_8;
            tdl     <= RESET_8;
            tcv     <= RESET_8;
            tx_control_one    <= RESET_8;
            tx_control_two    <= RESET_8;
            tx_latched_status_two    <= RESET_8;
            tx_interrupt_mask_two    <= RESET_8;
            irq_n   <= 1'b1;
        end else begin
            awready <= next_awready;
            wready  <= next_wready;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            arready <= next_arready;
            rvalid  <= next_rvalid;
            rresp   <= next_rresp;
            rdata   <= next_rdata;
            aw_addr <= next_aw_addr;
            w_data  <= next_w_data;
            w_lane  <= next_w_lane;
            rcc     <= next_rcc;
            rx_latched_status_seven    <= next_rx_latched_status_seven;
            rx_interrupt_mask_seven    <= next_rx_interrupt_mask_seven;
            tx_link_control_two    <= next_tx_link_control_two;
            tdl     <= next_tdl;
            tcv     <= next_tcv;
            tx_control_one    <= next_tx_control_one;
            tx_control_two    <= next_tx_control_two;
            tx_latched_status_two    <= next_tx_latched_status_two;
            tx_interrupt_mask_two    <= next_tx_interrupt_mask_two;
            irq_n   <= next_irq_n;
        end
    end

    assign s_axi_awready_o   = awready;
    assign s_axi_wready_o    = wready;
    assign s_axi_bvalid_o    = bvalid;
    assign s_axi_bresp_o     = bresp;
    assign s_axi_arready_o   = arready;
    assign s_axi_rvalid_o    = rvalid;
    assign s_axi_rresp_o     = rresp;
    assign s_axi_rdata_o     = rdata;
    assign tx_dl_bit_o       = tx_bit;
    assign interrupt_out_n_o = irq_n;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    a_det_sticky: assert property (rx_latched_status_seven[CODE_DET_BIT] && !(wen && wsel == SEL_RX_LATCHED_STATUS_SEVEN)
        |=> rx_latched_status_seven[CODE_DET_BIT]) else $error("detected flag dropped");
    a_irq_mask: assert property (|(rx_latched_status_seven & rx_interrupt_mask_seven) |=> !interrupt_out_n_o)
        else $error("unmasked flag gave no interrupt");
    a_irq_quiet: assert property (!(|((rx_latched_status_seven & rx_interrupt_mask_seven) | (tx_latched_status_two & tx_interrupt_mask_two))) |=> interrupt_out_n_o)
        else $error("interrupt without unmasked flag");
    a_pass_thru: assert property (tx_dl_slot_i && tx_control_one[PASS_THRU_BIT]
        |=> tx_dl_bit_o == $past(system_serial_input_i)) else $error("framing bit not kept");
    a_code_t1: assert property (tx_dl_slot_i && code_cnt == '0 && !t1_mode_i
        |=> code_cnt == '0) else $error("code sent outside T1");
    a_empty_set: assert property (tx_dl_slot_i && fdl_go && fdl_cnt == fdl_len - 4'h1
        |=> tx_latched_status_two[TX_EMPTY_BIT]) else $error("empty flag missing");
    a_rx_lsb: assert property (rx_dl_slot_i && esf_mode_i && rx_cnt == BITS_ESF - 4'h1
        |=> rx_byte == {$past(rx_dl_bit_i), $past(rx_sh[7:1])} && rx_latched_status_seven[RX_FULL_BIT])
        else $error("received byte wrong");
    a_det_code: assert property ($rose(rx_latched_status_seven[CODE_DET_BIT]) |-> $past(esf_mode_i)
        && rx_code == cand) else $error("detected code mismatch");
    a_clr_set: assert property (clr_evt |=> rx_latched_status_seven[CODE_CLR_BIT] && !code_act)
        else $error("cleared flag missing");
    a_wr_resp: assert property (do_wr |=> s_axi_bvalid_o [*1] ##0 !s_axi_awready_o)
        else $error("write answer missing");

    c_code_det: cover property ($rose(rx_latched_status_seven[CODE_DET_BIT]));
    c_code_clr: cover property ($rose(rx_latched_status_seven[CODE_CLR_BIT]));
    c_tx_empty: cover property ($rose(tx_latched_status_two[TX_EMPTY_BIT]));
    c_rx_full:  cover property ($rose(rx_latched_status_seven[RX_FULL_BIT]));
endmodule

// >>> tbf_line_model.sv
`timescale 1ns/1ns
module tbf_line_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] rx_pat_i,
    input  wire logic        tx_bit_i,
    output logic             slot_o,
    output logic             rx_bit_o,
    output logic             fbit_o,
    output logic [15:0]      tx_word_o
);
    logic [1:0] ph;
    logic [3:0] idx;
    logic       cap;
    // One slot every four cycles; a slow line against a fast bus
    assign slot_o = (ph == 2'd0) && !rst_i;
    // Off-slot the data line toggles, so a stale sample is caught
    assign rx_bit_o = slot_o ? rx_pat_i[idx] : ph[0];
    assign fbit_o = idx[0];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph <= 2'd0;
            idx <= 4'h0;
            cap <= 1'b0;
            tx_word_o <= 16'h0000;
        end else begin
            ph <= ph + 2'd1;
            cap <= slot_o;
            if (slot_o) idx <= idx + 4'h1;
            // First bit on the line ends up lowest after the shifts
            if (cap) tx_word_o <= {tx_bit_i, tx_word_o[15:1]};
        end
    end
endmodule

// >>> tbf_pkg.sv
package tbf_pkg;
    // Register indexes; the byte address is four times the index
    localparam logic [12:0] IX_RCC        = 13'h0015;
    localparam logic [12:0] IX_RDL        = 13'h0062;
    localparam logic [12:0] IX_RCV        = 13'h0063;
    localparam logic [12:0] IX_RX_LATCHED_STATUS_SEVEN       = 13'h0096;
    localparam logic [12:0] IX_RX_INTERRUPT_MASK_SEVEN       = 13'h00a6;
    localparam logic [12:0] IX_TX_LINK_CONTROL_TWO       = 13'h0113;
    localparam logic [12:0] IX_TDL        = 13'h0162;
    localparam logic [12:0] IX_TCV        = 13'h0163;
    localparam logic [12:0] IX_TX_CONTROL_ONE       = 13'h0181;
    localparam logic [12:0] IX_TX_CONTROL_TWO       = 13'h0182;
    localparam logic [12:0] IX_TX_LATCHED_STATUS_TWO       = 13'h0191;
    localparam logic [12:0] IX_TX_INTERRUPT_MASK_TWO       = 13'h01a1;
    localparam logic [12:0] FRAMER_STRIDE = 13'h0200;
    // Field positions
    localparam int SEND_CODE_BIT   = 6;
    localparam int PASS_THRU_BIT   = 6;
    localparam int DL_SRC_BIT      = 7;
    localparam int CODE_DET_BIT    = 0;
    localparam int CODE_CLR_BIT    = 1;
    localparam int RX_FULL_BIT     = 2;
    localparam int TX_EMPTY_BIT    = 4;
    localparam int FILT_LO         = 0;
    localparam int DIS_LO          = 4;
    localparam logic [7:0] RX_LATCHED_STATUS_SEVEN_USED = 8'h07;
    localparam logic [7:0] TX_LATCHED_STATUS_TWO_USED = 8'h10;
    localparam logic [7:0] RESET_8   = 8'h00;
    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Line framing
    localparam logic [3:0] BITS_ESF  = 4'h8;
    localparam logic [3:0] BITS_D4   = 4'h6;
    localparam logic [7:0] CODE_MARK = 8'hff;
    localparam logic [2:0] RUN_MAX   = 3'h7;
    localparam logic [7:0] ABS_MAX   = 8'hff;
    // Codewords needed to validate, and data link slots of absence to clear
    localparam logic [2:0] FILT_TBL [4] = '{3'h1, 3'h3, 3'h5, 3'h7};
    localparam logic [7:0] DIS_TBL  [4] = '{8'h20, 8'h40, 8'h80, 8'hff};
    typedef enum logic [3:0] {
        SEL_NONE, SEL_RCC, SEL_RDL, SEL_RCV, SEL_RX_LATCHED_STATUS_SEVEN, SEL_RX_INTERRUPT_MASK_SEVEN,
        SEL_TX_LINK_CONTROL_TWO, SEL_TDL, SEL_TCV, SEL_TX_CONTROL_ONE, SEL_TX_CONTROL_TWO, SEL_TX_LATCHED_STATUS_TWO, SEL_TX_INTERRUPT_MASK_TWO
    } tbf_sel_e;
    // Sent LSB first: 0, six code bits, 0, then eight ones
    function automatic logic [15:0] tbf_code_word(input logic [5:0] c);
        return {CODE_MARK, 1'b0, c, 1'b0};
    endfunction
endpackage

// >>> test_t1_boc_fdl_data_link.sv
`timescale 1ns/1ns
module test_t1_boc_fdl_data_link;
    import tbf_pkg::*;
    logic        clk, rst, awv, wv, br, arv, rr, esf, slot, rxb, fb, txb, intn;
    logic        awr, wrdy, arr, bv, rv, t1;
    logic [31:0] awa, wd, ara, rdat;
    logic [1:0]  bresp, rresp;
    logic [15:0] pat, word;
    logic [7:0]  b;
    logic [5:0]  c;
    int          failures, compares, cyc;
    tbf_data_link tbf_data_link_i (.sys_clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awa),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'h1),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
        .t1_mode_i(t1), .esf_mode_i(esf), .tx_dl_slot_i(slot), .system_serial_input_i(fb),
        .tx_dl_bit_o(txb), .rx_dl_slot_i(slot), .rx_dl_bit_i(rxb), .rx_multiframe_i(1'b0),
        .interrupt_out_n_o(intn));
    tbf_line_model tbf_line_model_i (.clk_i(clk), .rst_i(rst), .rx_pat_i(pat), .tx_bit_i(txb),
        .slot_o(slot), .rx_bit_o(rxb), .fbit_o(fb), .tx_word_o(word));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task summarize;
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // Address and data go out together; each is dropped once taken
    task wr(input logic [12:0] ix, input logic [7:0] d);
        awa <= {17'h0_0000, ix, 2'b00};
        wd <= {24'h00_0000, d};
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (!bv);
        br <= 1'b0;
        chk("bresp", RESP_OKAY, bresp);
    endtask
    task rd(input logic [12:0] ix, input logic [7:0] e, input logic [1:0] er, input logic [7:0] m);
        ara <= {17'h0_0000, ix, 2'b00};
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rr <= 1'b0;
        chk("rresp", er, rresp);
        chk("rdata", e, rdat & {24'h00_0000, m});
    endtask
    // Bounded search of the line for a bit pattern
    task ww(input logic [15:0] e, input logic [15:0] m);
        int i;
        for (i = 0; i < 600 && (word & m) !== e; i++) @(posedge clk);
        chk("line", e, word & m);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        {awv, wv, br, arv, rr, awa, wd, ara, pat} = '0;
        {failures, compares, cyc} = '0;
        rst = 1'b1;
        esf = 1'b1;
        t1 = 1'b1;
        void'($urandom(18));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(IX_TCV, 8'h00, RESP_OKAY, 8'hff);
        rd(13'h0000, 8'h00, RESP_SLVERR, 8'hff);
        c = 6'($urandom % 63);
        wr(IX_TCV, {2'b11, c});
        t1 <= 1'b0;
        wr(IX_TX_LINK_CONTROL_TWO, 8'h40);
        ww(16'haaaa, 16'hffff);
        t1 <= 1'b1;
        ww({8'hff, 1'b0, c, 1'b0}, 16'hffff);
        wr(IX_TX_CONTROL_ONE, 8'h40);
        ww(16'haaaa, 16'hffff);
        wr(IX_TX_LINK_CONTROL_TWO, 8'h00);
        wr(IX_TX_CONTROL_ONE, 8'h00);
        b = 8'($urandom);
        wr(IX_TX_CONTROL_TWO, 8'h80);
        wr(IX_TDL, b);
        ww({b, 8'h00}, 16'hff00);
        repeat (32) @(posedge clk);
        ww({b, b}, 16'hffff);
        rd(IX_TX_LATCHED_STATUS_TWO, 8'h10, RESP_OKAY, 8'h10);
        wr(IX_TX_INTERRUPT_MASK_TWO, 8'h10);
        repeat (2) @(posedge clk);
        chk("irq", 1'b0, intn);
        wr(IX_TX_INTERRUPT_MASK_TWO, 8'h00);
        repeat (2) @(posedge clk);
        chk("irq", 1'b1, intn);
        esf <= 1'b0;
        wr(IX_TX_CONTROL_TWO, 8'h00);
        wr(IX_TDL, 8'hdc);
        ww(16'h71c0, 16'hfff0);
        esf <= 1'b1;
        // D4 froze the byte counter; a reset lines it up with the line again
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        pat <= {b, b};
        repeat (80) @(posedge clk);
        rd(IX_RDL, b, RESP_OKAY, 8'hff);
        rd(IX_RX_LATCHED_STATUS_SEVEN, 8'h04, RESP_OKAY, 8'h04);
        pat <= {8'hff, 1'b0, c, 1'b0};
        wr(IX_RX_INTERRUPT_MASK_SEVEN, 8'h01);
        repeat (200) @(posedge clk);
        rd(IX_RCV, {2'b00, c}, RESP_OKAY, 8'hff);
        rd(IX_RX_LATCHED_STATUS_SEVEN, 8'h01, RESP_OKAY, 8'h01);
        chk("irq", 1'b0, intn);
        pat <= 16'h0000;
        repeat (300) @(posedge clk);
        rd(IX_RX_LATCHED_STATUS_SEVEN, 8'h02, RESP_OKAY, 8'h02);
        summarize();
    end
endmodule
